// ===== src/otp_pkg.sv
// Constants shared by the over-temperature comparator and its register bank.
// Assumes a 9-bit temperature-sense reading with the same code step as the limit.
package otp_pkg;

  // Data widths
  localparam int unsigned LIM_W  = 8;
  localparam int unsigned ADC_W  = 9;
  localparam int unsigned SUM_W  = 10;
  localparam int unsigned EVT_W  = 2;
  localparam int unsigned DATA_W = 32;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_READING = 8'h1A;
  localparam logic [7:0] IDX_LIMIT   = 8'h2F;
  localparam logic [7:0] IDX_STATUS  = 8'h40;
  localparam logic [7:0] IDX_CLEAR   = 8'h41;
  localparam logic [7:0] IDX_ENABLE  = 8'h42;
  localparam logic [7:0] IDX_FLAG    = 8'h43;

  // Address slicing: word index sits above the two byte bits
  localparam int unsigned IDX_LSB  = 2;
  localparam int unsigned IDX_MSB  = 9;
  localparam int unsigned ADDR_W   = 12;

  // Event bits in status, clear and enable registers
  localparam int unsigned EVT_SET = 0;
  localparam int unsigned EVT_CLR = 1;

  // Analog scale: one code is 3.04 mV, reading spans 0 V to 1.55 V
  localparam int unsigned STEP_UV  = 3040;
  localparam int unsigned RANGE_UV = 1550000;
  localparam int unsigned HYST_UV  = 16000;
  // Hysteresis in whole codes, rounded to nearest (16 mV -> 5 codes)
  localparam logic [SUM_W-1:0] HYST_CODES = SUM_W'((HYST_UV + STEP_UV / 2) / STEP_UV);
  // Codes needed to cover the whole sense range at one step per code
  localparam int unsigned RANGE_CODES = (RANGE_UV + STEP_UV - 1) / STEP_UV;

  // Reset values
  localparam logic [LIM_W-1:0] LIMIT_RST   = 8'h00;
  localparam logic [ADC_W-1:0] READING_RST = 9'h1FF;

  // Flag state machine, one-hot
  typedef enum logic [1:0] {
    FLAG_COOL = 2'b01,
    FLAG_HOT  = 2'b10
  } flag_state_e;

endpackage

// ===== src/cmp_if.sv
// Carrier between the register bank and the hysteresis comparator.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface cmp_if;
  logic [otp_pkg::ADC_W-1:0] reading;
  logic [otp_pkg::LIM_W-1:0] limit;
  logic                      hot;
  logic                      rise;
  logic                      fall;

  modport ctrl (output reading, output limit, input hot, input rise, input fall);
  modport cmp  (input reading, input limit, output hot, output rise, output fall);
endinterface

// ===== src/otp_compare.sv
// Hysteresis comparator for the over-temperature flag.
// Assumes reading and limit share one code step and are stable registers.
`timescale 1ns/10ps
module otp_compare (
  input  wire logic pclk,
  input  wire logic presetn,
  cmp_if.cmp        c
);

  typedef struct packed {
    otp_pkg::flag_state_e st;
    logic                 rise;
    logic                 fall;
  } cmp_s;

  cmp_s                        q;
  cmp_s                        d;
  logic [otp_pkg::SUM_W-1:0]   release_lvl;
  logic [otp_pkg::SUM_W-1:0]   reading_w;
  logic [otp_pkg::SUM_W-1:0]   limit_w;

  // Widen both sides so limit plus hysteresis never wraps
  assign reading_w   = otp_pkg::SUM_W'(c.reading);
  assign limit_w     = otp_pkg::SUM_W'(c.limit);
  assign release_lvl = limit_w + otp_pkg::HYST_CODES;

  // Next state; evaluated every cycle on the latest reading
  always_comb begin
    d      = q;
    d.rise = 1'b0;
    d.fall = 1'b0;
    case (q.st)
      otp_pkg::FLAG_COOL: begin
        // Low reading means hot thermistor
        if (reading_w < limit_w) begin
          d.st   = otp_pkg::FLAG_HOT;
          d.rise = 1'b1;
        end
      end
      otp_pkg::FLAG_HOT: begin
        // Needs the full band to clear, so noise cannot chatter the flag
        if (reading_w >= release_lvl) begin
          d.st   = otp_pkg::FLAG_COOL;
          d.fall = 1'b1;
        end
      end
      default: d.st = otp_pkg::FLAG_COOL;
    endcase
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '{st: otp_pkg::FLAG_COOL, rise: 1'b0, fall: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign c.hot  = (q.st == otp_pkg::FLAG_HOT);
  assign c.rise = q.rise;
  assign c.fall = q.fall;

endmodule

// ===== src/overtemp_threshold_compare.sv
// Over-temperature threshold comparator with its APB register bank.
// Assumes the temperature-sense reading arrives on pclk with a valid strobe,
// one code per 3.04 mV, and an APB3 master on the same clock.
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/10ps

module overtemp_threshold_compare #(
  parameter logic [otp_pkg::LIM_W-1:0] LIMIT_RESET = otp_pkg::LIMIT_RST
) (
  input  wire  logic                        pclk,
  input  wire  logic                        presetn,
  input  wire  logic                        psel,
  input  wire  logic                        penable,
  input  wire  logic                        pwrite,
  input  wire  logic [otp_pkg::ADDR_W-1:0]  paddr,
  input  wire  logic [otp_pkg::DATA_W-1:0]  pwdata,
  output logic       [otp_pkg::DATA_W-1:0]  prdata,
  output logic                              pready,
  output logic                              pslverr,
  input  wire  logic                        temp_sense_adc_valid,
  input  wire  logic [otp_pkg::ADC_W-1:0]   temp_sense_adc_data,
  output logic                              overtemp_flag,
  output logic                              irq
);

  // Index slice width, taken from the shared address layout
  localparam int unsigned IDX_W = otp_pkg::IDX_MSB - otp_pkg::IDX_LSB + 1;

  // Whole module state in one record
  // One comb fills d, one flop block holds q
  typedef struct packed {
    logic [otp_pkg::LIM_W-1:0]  limit;   // Threshold code
    logic [otp_pkg::ADC_W-1:0]  reading; // Latest sense code
    logic [otp_pkg::EVT_W-1:0]  sts;     // Sticky flag edges
    logic [otp_pkg::EVT_W-1:0]  en;      // Interrupt enables
    logic [otp_pkg::DATA_W-1:0] rdata;   // Read word from setup
    logic                       err;     // Refusal from setup
  } regs_s;

  // Power-up contents: cold reading, no events, nothing enabled
  localparam regs_s REGS_RST = '{
    limit:   LIMIT_RESET,
    reading: otp_pkg::READING_RST,
    sts:     '0,
    en:      '0,
    rdata:   '0,
    err:     1'b0
  };

  regs_s                       q;
  regs_s                       d;
  logic [IDX_W-1:0]            idx;
  logic                        aligned;
  logic                        setup_ph;
  logic                        access_ph;
  logic                        wr_acc;
  logic                        wr_limit;
  logic                        wr_enable;
  logic                        wr_clear;
  logic                        mapped;
  logic                        read_only;
  logic [otp_pkg::EVT_W-1:0]   evt;
  logic [otp_pkg::EVT_W-1:0]   clr;
  logic [otp_pkg::EVT_W-1:0]   sts_nxt;
  logic [otp_pkg::DATA_W-1:0]  rd_word;
  logic                        rd_err;

  // Register map by word index; byte address is four times the index
  //   reading  read only   latest temperature-sense code
  //   limit    read/write  threshold code, one step per reading code
  //   status   read only   bit 0 flag set, bit 1 flag cleared
  //   clear    write only  one drops a status bit, reads as zero
  //   enable   read/write  interrupt enables, status layout
  //   flag     read only   bit 0 live over-temperature flag
  // Every other word is unmapped and refused with pslverr.
  // Out-of-span limit codes are stored as written; range is software's job.

  // Carrier to the comparator; one clock, so no crossing
  cmp_if cif ();

  // Comparator sees registered limit and reading only,
  // so a bus write never meets a half-updated compare
  assign cif.limit   = q.limit;
  assign cif.reading = q.reading;

  // Flag and hysteresis live here; its state flop drives the flag directly
  otp_compare u_cmp (
    .pclk    (pclk),
    .presetn (presetn),
    .c       (cif)
  );

  // Address decode; upper and byte bits must be zero to hit a register
  // An alias above the index bits would otherwise hit a real register
  assign idx       = paddr[otp_pkg::IDX_MSB:otp_pkg::IDX_LSB];
  assign aligned   = (paddr[otp_pkg::IDX_LSB-1:0] == '0)
                   && (paddr[otp_pkg::ADDR_W-1:otp_pkg::IDX_MSB+1] == '0);

  // Phase strobes; nothing happens while psel is low
  assign setup_ph  = psel && !penable;
  assign access_ph = psel && penable;
  assign wr_acc    = access_ph && pwrite && aligned;

  // One strobe per writable word, all on the access edge
  // Writes to read-only words decode to no strobe and change nothing
  assign wr_limit  = wr_acc && (idx == otp_pkg::IDX_LIMIT);
  assign wr_enable = wr_acc && (idx == otp_pkg::IDX_ENABLE);
  assign wr_clear  = wr_acc && (idx == otp_pkg::IDX_CLEAR);

  // Which indices exist and which refuse writes;
  // clear reads as zero with no error, so software may poll it harmlessly
  always_comb begin
    mapped    = 1'b0;
    read_only = 1'b0;
    if (aligned) begin
      case (idx)
        // Writable words
        otp_pkg::IDX_LIMIT,
        otp_pkg::IDX_CLEAR,
        otp_pkg::IDX_ENABLE: mapped = 1'b1;
        // Read-only words
        otp_pkg::IDX_READING,
        otp_pkg::IDX_STATUS,
        otp_pkg::IDX_FLAG: begin
          mapped    = 1'b1;
          read_only = 1'b1;
        end
        default: mapped = 1'b0;
      endcase
    end
  end

  // Flag edges become sticky events
  // Comparator pulses last one cycle, so each edge sets at most once
  assign evt[otp_pkg::EVT_SET] = cif.rise;
  assign evt[otp_pkg::EVT_CLR] = cif.fall;

  // Write-one-to-clear, only on the access edge
  // Bits of the clear word above the event bits are ignored
  assign clr = wr_clear ? pwdata[otp_pkg::EVT_W-1:0] : '0;

  // One sticky bit per event; set wins over a clear in the same cycle,
  // so an edge that lands on a clear write is never lost
  for (genvar i = 0; i < otp_pkg::EVT_W; i++) begin : g_sts
    assign sts_nxt[i] = evt[i] || (q.sts[i] && !clr[i]);
  end

  // Read word and refusal worked out for the setup edge;
  // a refused read returns zero, never a neighbouring word
  always_comb begin
    rd_word = '0;
    rd_err  = !mapped || (pwrite && read_only);
    if (mapped && !pwrite) begin
      case (idx)
        otp_pkg::IDX_READING: rd_word = otp_pkg::DATA_W'(q.reading);
        otp_pkg::IDX_LIMIT:   rd_word = otp_pkg::DATA_W'(q.limit);
        otp_pkg::IDX_STATUS:  rd_word = otp_pkg::DATA_W'(q.sts);
        otp_pkg::IDX_ENABLE:  rd_word = otp_pkg::DATA_W'(q.en);
        otp_pkg::IDX_FLAG:    rd_word = otp_pkg::DATA_W'(cif.hot);
        default:              rd_word = '0;
      endcase
    end
  end

  // Next value of every register
  // Starts from q so an untouched field simply holds
  always_comb begin
    d = q;

    // Every valid overwrites; no filtering, hysteresis alone absorbs noise
    if (temp_sense_adc_valid) begin
      d.reading = temp_sense_adc_data;
    end

    // Events and clears, already merged per bit
    d.sts = sts_nxt;

    // Captured at setup so prdata comes from a flop and stands through access
    if (setup_ph) begin
      d.rdata = rd_word;
      d.err   = rd_err;
    end

    // Limit code is in 3.04 mV steps, same as the reading
    if (wr_limit) begin
      d.limit = pwdata[otp_pkg::LIM_W-1:0];
    end
    if (wr_enable) begin
      d.en = pwdata[otp_pkg::EVT_W-1:0];
    end
  end

  // Register the whole state; reset loads constants only,
  // so its release cannot race a data path
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= REGS_RST;
    end else begin
      q <= d;
    end
  end

  // Zero-wait slave; data and error were settled during setup
  // pready is tied high, so the master never waits
  assign pready  = 1'b1;
  assign prdata  = q.rdata;
  assign pslverr = access_ph && q.err;

  // Level interrupt while any enabled event is pending;
  // dropping the event or its enable releases it on the next edge
  assign irq           = |(q.sts & q.en);
  assign overtemp_flag = cif.hot;

endmodule

// ===== dv/otp_props.sv
// Port checker for the over-temperature comparator.
// Assumes limit writes commit at the APB access edge.
`timescale 1ns/10ps
module otp_props #(
  parameter logic [7:0] LIM_RST = 8'h00
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        overtemp_flag,
  input wire logic        irq,
  input wire logic        temp_sense_adc_valid,
  input wire logic [8:0]  temp_sense_adc_data
);
  logic [8:0] rd_q;
  logic [9:0] lim_q;
  wire        acc = psel & penable & pready;
  wire        lo  = {1'b0, rd_q} < lim_q;
  wire        hi  = {1'b0, rd_q} >= lim_q + 10'h005;
  // Shadow copies of the stored reading and limit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_q  <= 9'h1FF;
      lim_q <= {2'h0, LIM_RST};
    end else begin
      if (temp_sense_adc_valid)
        rd_q <= temp_sense_adc_data;
      if (acc && pwrite && paddr == 12'h0BC)
        lim_q <= {2'h0, pwdata[7:0]};
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_set; lo |=> overtemp_flag; endproperty
  property p_cool; !overtemp_flag && !lo |=> !overtemp_flag; endproperty
  property p_hold; overtemp_flag && !hi |=> overtemp_flag; endproperty
  property p_clr; overtemp_flag && hi |=> !overtemp_flag; endproperty
  property p_rd;
    acc && !pwrite && paddr == 12'h068 |-> prdata == {23'h0, $past(rd_q)};
  endproperty
  property p_lim;
    acc && !pwrite && paddr == 12'h0BC |-> prdata == {22'h0, $past(lim_q)};
  endproperty
  a_set: assert property (p_set) else $error("flag not set below limit");
  a_cool: assert property (p_cool) else $error("flag set at or above limit");
  a_hold: assert property (p_hold) else $error("flag dropped inside band");
  a_clr: assert property (p_clr) else $error("flag kept above band");
  a_rd: assert property (p_rd) else $error("reading readback wrong");
  a_lim: assert property (p_lim) else $error("limit readback wrong");
  c_hot: cover property ($rose(overtemp_flag));
  c_cool: cover property ($fell(overtemp_flag));
  c_irq: cover property ($rose(irq));
endmodule
bind overtemp_threshold_compare otp_props #(.LIM_RST(LIMIT_RESET)) chk (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .overtemp_flag, .irq,
  .temp_sense_adc_valid, .temp_sense_adc_data);

// ===== dv/otp_adc_model.sv
// Model of the internal temperature-sense result path.
// Assumes one req pulse per conversion from the bench.
`timescale 1ns/10ps
module otp_adc_model (
  input  wire logic       pclk,
  input  wire logic       req,
  input  wire logic [8:0] code,
  output logic            vld,
  output logic [8:0]      dat
);
  int unsigned n_q = 0;
  logic [8:0]  c_q = 9'h000;
  initial vld = 1'b0;
  initial dat = 9'h000;
  // Random latency; data inverts every cycle outside valid, so a stale code shows only on alternate cycles
  always @(posedge pclk) begin
    vld <= 1'b0;
    dat <= ~dat;
    if (req) begin
      c_q <= code;
      n_q <= $urandom_range(4, 1);
    end else if (n_q == 1) begin
      vld <= 1'b1;
      dat <= c_q;
      n_q <= 0;
    end else if (n_q > 1)
      n_q <= n_q - 1;
  end
endmodule

// ===== dv/test_overtemp_threshold_compare.sv
// Self-checking bench for the over-temperature comparator.
// Assumes zero-wait APB and the result-path model beside the design.
`timescale 1ns/10ps
module test_overtemp_threshold_compare;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        req = 1'b0, vld, pready, pslverr, flag, irq;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [8:0]  code = 9'h000, dat;
  logic [33:0] exp_q[$], nt;
  logic        ef_q[$];
  logic [2:0]  vld_sr = 3'h0;
  int          n_mismatch = 0, total_checks = 0, cyc = 0, lim;
  overtemp_threshold_compare uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .temp_sense_adc_valid(vld),
    .temp_sense_adc_data(dat), .overtemp_flag(flag), .irq);
  otp_adc_model adc (.pclk, .req, .code, .vld, .dat);
  initial forever #2.5 pclk = ~pclk;
  task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
    total_checks++;
    if (e !== s) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  // One APB transfer; the expectation goes to the scoreboard first
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d, logic er, logic [31:0] e);
    @(posedge pclk);
    exp_q.push_back({w, er, e});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Conversion through the model; the expected flag waits in its own queue
  task automatic sense(int c, logic ef);
    @(posedge pclk);
    ef_q.push_back(ef);
    req <= 1'b1;
    code <= 9'(c);
    @(posedge pclk);
    req <= 1'b0;
    do @(posedge pclk); while (vld !== 1'b1);
    repeat (3) @(posedge pclk);
  endtask
  task automatic irq_is(logic e);
    #1;
    chk("irq", {31'h0, e}, {31'h0, irq});
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Scoreboard: each finished transfer retires the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      nt = exp_q.pop_front();
      chk("pslverr", {31'h0, nt[32]}, {31'h0, pslverr});
      if (!nt[33])
        chk("prdata", nt[31:0], prdata);
    end
  end
  // Flag watcher: three edges after a capture the flag has settled
  always @(posedge pclk) begin
    vld_sr <= {vld_sr[1:0], vld};
    if (vld_sr[2])
      chk("overtemp_flag", {31'h0, ef_q.pop_front()}, {31'h0, flag});
  end
  // Hang guard, far above the few hundred cycles needed
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  initial begin
    void'($urandom(32'h57B29235));
    repeat (16) @(posedge pclk);
    chk("pready", 32'h1, {31'h0, pready});
    chk("irq", 32'h0, {31'h0, irq});
    presetn <= 1'b1;
    apb(0, 12'h0BC, 0, 0, 0);
    apb(0, 12'h068, 0, 0, 32'h1FF);
    apb(1, 12'h068, 5, 1, 0);
    apb(0, 12'h3FC, 0, 1, 0);
    for (int i = 0; i < 4; i++) begin
      lim = $urandom_range(250, 3);
      apb(1, 12'h0BC, lim, 0, 0);
      apb(0, 12'h0BC, 0, 0, lim);
      sense(lim - 1, 1'b1);
      apb(0, 12'h068, 0, 0, lim - 1);
      sense(lim + 4, 1'b1);
      apb(0, 12'h10C, 0, 0, 1);
      sense(lim + 5, 1'b0);
      sense(lim, 1'b0);
    end
    apb(0, 12'h0BD, 0, 1, 0);
    apb(1, 12'h8BC, 0, 1, 0);
    apb(0, 12'h0BC, 0, 0, lim);
    apb(1, 12'h10C, 1, 1, 0);
    apb(0, 12'h100, 0, 0, 3);
    apb(1, 12'h100, 0, 1, 0);
    irq_is(1'b0);
    apb(1, 12'h108, 3, 0, 0);
    irq_is(1'b1);
    apb(1, 12'h108, 0, 0, 0);
    irq_is(1'b0);
    apb(1, 12'h108, 3, 0, 0);
    apb(1, 12'h104, 1, 0, 0);
    irq_is(1'b1);
    apb(1, 12'h104, 2, 0, 0);
    irq_is(1'b0);
    apb(0, 12'h100, 0, 0, 0);
    apb(0, 12'h104, 0, 0, 0);
    print_verdict();
  end
endmodule
